/* core/iord_chmap_if.sv */
// carrier between the dispatcher and its channel map store
// assumes both ends share clk_i
`timescale 1ns/1ps
interface iord_chmap_if;
  import iord_pkg::*;
  logic wr_en;
  logic [CHAN_W-1:0] wr_addr;
  logic [ENT_W-1:0] wr_data;
  logic [CHAN_W-1:0] rd_addr;
  logic [ENT_W-1:0] rd_data;

  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
                 input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data);
endinterface : iord_chmap_if

/* core/iord_chmap_mem.sv */
// channel route table: channel number to holder, quadrant and group
// assumes synchronous reset; read data are registered, one cycle late
`timescale 1ns/1ps
module iord_chmap_mem (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // table port
  iord_chmap_if.store mem
);
  import iord_pkg::*;

  logic [ENT_W-1:0] table_q [N_CHAN];
  logic [ENT_W-1:0] rd_q;
  logic [ENT_W-1:0] rd_d;

  // read of an old entry; write during read returns the old value
  always_comb begin
    rd_d = table_q[mem.rd_addr];
  end

  // array carries no reset, so software must load routes before use
  always_ff @(posedge clk_i) begin
    if (mem.wr_en) begin
      table_q[mem.wr_addr] <= mem.wr_data;
    end
  end

  // registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign mem.rd_data = rd_q;

endmodule : iord_chmap_mem

/* core/iord_dispatch.sv */
// shared-side I/O request router and per-group interrupt token rings
// assumes one clock, synchronous reset, and a classic Wishbone master
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module iord_dispatch (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone register port
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [iord_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [iord_pkg::WB_DW-1:0] wb_dat_i,
  output logic [iord_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt from IO modules
  input wire logic io_irq_i,
  input wire logic [iord_pkg::GROUP_W-1:0] io_irq_group_i,
  // processor command input
  input wire logic cmd_valid_i,
  input wire logic [iord_pkg::PROC_W-1:0] cmd_src_i,
  input wire logic [iord_pkg::CMD_W-1:0] cmd_code_i,
  input wire logic [iord_pkg::AJ_W-1:0] cmd_aj_i,
  input wire logic [iord_pkg::AK_W-1:0] cmd_ak_i,
  // forwarded request toward the IO module
  output logic fwd_valid_o,
  output logic [iord_pkg::PROC_W-1:0] fwd_via_o,
  output logic [iord_pkg::QUAD_W-1:0] fwd_quadrant_o,
  output logic [iord_pkg::PROC_W-1:0] fwd_target_o,
  output logic [iord_pkg::GROUP_W-1:0] fwd_group_o,
  output logic [iord_pkg::PROC_W-1:0] fwd_src_o,
  output logic [iord_pkg::CMD_W-1:0] fwd_code_o,
  output logic [iord_pkg::AJ_W-1:0] fwd_aj_o,
  output logic [iord_pkg::AK_W-1:0] fwd_ak_o,
  output logic cmd_reject_o,
  // interrupt to processors
  output logic [iord_pkg::N_PROC-1:0] proc_irq_o
);
  import iord_pkg::*;
  // byte-lane merge for register writes
  function automatic logic [WB_DW-1:0] lane_merge(input logic [WB_DW-1:0] old_v,
                                                 input logic [WB_DW-1:0] new_v,
                                                 input logic [3:0] sel);
    logic [WB_DW-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge
  // group field of a processor configuration word
  function automatic logic [GROUP_W-1:0] cfg_group(input logic [PCFG_W-1:0] c);
    return c[PCFG_GRP_LSB +: GROUP_W];
  endfunction : cfg_group
  // node test: group match and process state able to take an interrupt
  function automatic logic node_fits(input logic [PCFG_W-1:0] c,
                                     input logic [GROUP_W-1:0] g);
    return (cfg_group(c) == g) && c[PCFG_ACCEPT] && c[PCFG_MODEIO];
  endfunction : node_fits
  iord_chmap_if chmap ();
  iord_chmap_mem u_chmap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mem(chmap)
  );

  // scoreboards and token rings, one per group; status reads need them early
  iord_ring_state_type state_q [N_GROUP];
  iord_ring_state_type state_d [N_GROUP];
  logic [PROC_W-1:0] tok_q [N_GROUP];
  logic [PROC_W-1:0] tok_d [N_GROUP];
  logic [CNT_W-1:0] pend_q [N_GROUP];
  logic [CNT_W-1:0] pend_d [N_GROUP];
  logic [N_GROUP-1:0] idle_q, idle_d;
  logic [N_PROC-1:0] irq_d;
  logic [CNT_W+1:0] sum;
  logic [CMD_W-1:0] int_cmd [N_GROUP];
  // register file state
  logic ctrl_q, ctrl_d;
  logic [N_QUAD*PROC_W-1:0] quadmap_q, quadmap_d;
  logic [PCFG_W-1:0] pcfg_q [N_PROC];
  logic [PCFG_W-1:0] pcfg_d [N_PROC];
  logic ack_q, ack_d;
  logic [WB_DW-1:0] rdat_q, rdat_d, qm_full;
  logic [N_GROUP-1:0] done_wr;
  logic wb_req, wb_wr;

  // one access per request; ack drops the cycle after it was given
  always_comb begin
    wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    wb_wr = wb_req && wb_we_i;
    ack_d = wb_req;
    ctrl_d = ctrl_q;
    quadmap_d = quadmap_q;
    pcfg_d = pcfg_q;
    done_wr = '0;
    rdat_d = '0;
    qm_full = lane_merge({{(WB_DW-N_QUAD*PROC_W){1'b0}}, quadmap_q}, wb_dat_i, wb_sel_i);
    chmap.wr_en = 1'b0;
    chmap.wr_addr = wb_dat_i[CHMAP_CHAN_LSB +: CHAN_W];
    chmap.wr_data = wb_dat_i[CHMAP_ENT_LSB +: ENT_W];
    if (wb_wr) begin
      case (wb_adr_i)
        REG_CTRL: ctrl_d = wb_sel_i[0] ? wb_dat_i[CTRL_RING_EN] : ctrl_q;
        REG_QUADMAP: quadmap_d = qm_full[N_QUAD*PROC_W-1:0];
        REG_CHMAP: chmap.wr_en = wb_sel_i[0] && wb_sel_i[1];
        REG_DONE: done_wr = wb_sel_i[0] ? wb_dat_i[N_GROUP-1:0] : '0;
        default: begin
          if (wb_adr_i >= REG_PCFG_BASE && wb_adr_i <= REG_PCFG_LAST && wb_sel_i[0]) begin
            pcfg_d[wb_adr_i[5:2]] = wb_dat_i[PCFG_W-1:0];
          end
        end
      endcase
    end
    // reads see this cycle's state; unmapped words read zero
    case (wb_adr_i)
      REG_CTRL: rdat_d[CTRL_RING_EN] = ctrl_q;
      REG_STATUS: begin
        for (int g = 0; g < N_GROUP; g++) begin
          rdat_d[STAT_IDLE_LSB + g] = idle_q[g];
          rdat_d[STAT_SEEK_LSB + g] = (state_q[g] == RING_SEEK);
        end
      end
      REG_PENDING: begin
        for (int g = 0; g < N_GROUP; g++) begin
          rdat_d[CNT_W*g +: CNT_W] = pend_q[g];
        end
      end
      REG_HOLDER: begin
        for (int g = 0; g < N_GROUP; g++) begin
          rdat_d[PROC_W*g +: PROC_W] = tok_q[g];
        end
      end
      REG_QUADMAP: rdat_d[N_QUAD*PROC_W-1:0] = quadmap_q;
      default: begin
        if (wb_adr_i >= REG_PCFG_BASE && wb_adr_i <= REG_PCFG_LAST) begin
          rdat_d[PCFG_W-1:0] = pcfg_q[wb_adr_i[5:2]];
        end
      end
    endcase
  end

  // register file flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      ctrl_q <= CTRL_RESET;
      quadmap_q <= '0;
      for (int p = 0; p < N_PROC; p++) begin
        pcfg_q[p] <= PCFG_RESET;
      end
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
      quadmap_q <= quadmap_d;
      pcfg_q <= pcfg_d;
    end
  end
  // request path: stage 0 checks the source, stage 1 holds the lookup
  logic s1_valid_q, s1_valid_d;
  logic [PROC_W-1:0] s1_src_q, s1_src_d;
  logic [CMD_W-1:0] s1_code_q, s1_code_d;
  logic [AJ_W-1:0] s1_aj_q, s1_aj_d;
  logic [AK_W-1:0] s1_ak_q, s1_ak_d;
  logic [N_GROUP-1:0] set_cmd;
  logic rej0;
  logic [PCFG_W-1:0] src_cfg;
  // only the set-interrupt code bypasses routing; others need a channel
  always_comb begin
    src_cfg = pcfg_q[cmd_src_i];
    set_cmd = '0;
    rej0 = 1'b0;
    s1_valid_d = 1'b0;
    s1_src_d = cmd_src_i;
    s1_code_d = cmd_code_i;
    s1_aj_d = cmd_aj_i;
    s1_ak_d = cmd_ak_i;
    chmap.rd_addr = cmd_aj_i[CHAN_W-1:0];
    if (cmd_valid_i) begin
      if (!src_cfg[PCFG_ORIG] || !src_cfg[PCFG_SHARED]) begin
        rej0 = 1'b1;
      end else if (cmd_code_i == CMD_SET_IRQ) begin
        set_cmd[cfg_group(src_cfg)] = 1'b1;
      end else begin
        s1_valid_d = 1'b1;
      end
    end
  end
  // forward stage outputs
  logic fwd_valid_d, reject_d;
  logic [PROC_W-1:0] via_d, target_d;
  logic [QUAD_W-1:0] quad_d;
  logic [GROUP_W-1:0] grp_d;
  // high-speed transfers never show up here, so no completion path exists
  always_comb begin
    target_d = chmap.rd_data[ENT_PROC_LSB +: PROC_W];
    quad_d = chmap.rd_data[ENT_QUAD_LSB +: QUAD_W];
    grp_d = chmap.rd_data[ENT_GRP_LSB +: GROUP_W];
    via_d = quadmap_q[PROC_W*quad_d +: PROC_W];
    fwd_valid_d = 1'b0;
    reject_d = rej0;
    if (s1_valid_q) begin
      if (pcfg_q[via_d][PCFG_PASS] && cfg_group(pcfg_q[s1_src_q]) == grp_d) begin
        fwd_valid_d = 1'b1;
      end else begin
        reject_d = 1'b1;
      end
    end
  end
  // request path flops; payload held while no new forward
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_valid_q <= 1'b0;
      fwd_valid_o <= 1'b0;
      cmd_reject_o <= 1'b0;
      fwd_via_o <= '0;
      fwd_quadrant_o <= '0;
      fwd_target_o <= '0;
      fwd_group_o <= '0;
      fwd_src_o <= '0;
      fwd_code_o <= '0;
      fwd_aj_o <= '0;
      fwd_ak_o <= '0;
    end else begin
      s1_valid_q <= s1_valid_d;
      s1_src_q <= s1_src_d;
      s1_code_q <= s1_code_d;
      s1_aj_q <= s1_aj_d;
      s1_ak_q <= s1_ak_d;
      fwd_valid_o <= fwd_valid_d;
      cmd_reject_o <= reject_d;
      if (fwd_valid_d) begin
        fwd_via_o <= via_d;
        fwd_quadrant_o <= quad_d;
        fwd_target_o <= target_d;
        fwd_group_o <= grp_d;
        fwd_src_o <= s1_src_q;
        fwd_code_o <= s1_code_q;
        fwd_aj_o <= s1_aj_q;
        fwd_ak_o <= s1_ak_q;
      end
    end
  end

  // a set in the same cycle as a retire is counted, never lost
  always_comb begin
    irq_d = '0;
    sum = '0;
    for (int g = 0; g < N_GROUP; g++) begin
      state_d[g] = state_q[g];
      tok_d[g] = tok_q[g];
      idle_d[g] = idle_q[g];
      // retiring a serviced interrupt rides the internal clear code
      int_cmd[g] = (done_wr[g] && state_q[g] == RING_BUSY) ? CMD_CLEAR_IRQ : '0;
      sum = {2'b00, pend_q[g]}
            + {{(CNT_W+1){1'b0}}, io_irq_i && io_irq_group_i == GROUP_W'(g)}
            + {{(CNT_W+1){1'b0}}, set_cmd[g]}
            - {{(CNT_W+1){1'b0}}, int_cmd[g] == CMD_CLEAR_IRQ};
      pend_d[g] = (sum > {2'b00, {CNT_W{1'b1}}}) ? {CNT_W{1'b1}} : sum[CNT_W-1:0];
      case (state_q[g])
        RING_WAIT: begin
          if (ctrl_q && pend_q[g] != '0 && idle_q[g]) begin
            state_d[g] = RING_SEEK;
          end
        end
        RING_SEEK: begin
          if (node_fits(pcfg_q[tok_q[g]], GROUP_W'(g))) begin
            irq_d[tok_q[g]] = 1'b1;
            idle_d[g] = 1'b0;
            state_d[g] = RING_BUSY;
          end else begin
            tok_d[g] = tok_q[g] + PROC_W'(1);
          end
        end
        RING_BUSY: begin
          if (int_cmd[g] == CMD_CLEAR_IRQ) begin
            idle_d[g] = 1'b1;
            state_d[g] = RING_WAIT;
          end
        end
        default: state_d[g] = RING_WAIT;
      endcase
    end
  end
  // ring flops; token keeps its place so the search restarts at the holder
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int g = 0; g < N_GROUP; g++) begin
        state_q[g] <= RING_WAIT;
        tok_q[g] <= '0;
        pend_q[g] <= '0;
      end
      idle_q <= '1;
      proc_irq_o <= '0;
    end else begin
      state_q <= state_d;
      tok_q <= tok_d;
      pend_q <= pend_d;
      idle_q <= idle_d;
      proc_irq_o <= irq_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule : iord_dispatch

/* core/iord_pkg.sv */
// constants and types for the I/O interrupt ring dispatch block
// assumes one 100 MHz clock and a classic Wishbone register port
package iord_pkg;

  // sizes of the processor complex
  localparam int N_PROC = 16;
  localparam int PROC_W = 4;
  localparam int N_GROUP = 4;
  localparam int GROUP_W = 2;
  localparam int N_QUAD = 4;
  localparam int QUAD_W = 2;
  localparam int N_CHAN = 256;
  localparam int CHAN_W = 8;
  localparam int CMD_W = 6;
  localparam int AJ_W = 8;
  localparam int AK_W = 40;
  localparam int CNT_W = 8;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;

  // command codes on the shared path (octal 64 and 65)
  localparam logic [CMD_W-1:0] CMD_SET_IRQ = 6'h34;
  localparam logic [CMD_W-1:0] CMD_CLEAR_IRQ = 6'h35;

  // register byte offsets
  localparam logic [WB_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [WB_AW-1:0] REG_PENDING = 8'h08;
  localparam logic [WB_AW-1:0] REG_HOLDER = 8'h0C;
  localparam logic [WB_AW-1:0] REG_CHMAP = 8'h10;
  localparam logic [WB_AW-1:0] REG_DONE = 8'h14;
  localparam logic [WB_AW-1:0] REG_QUADMAP = 8'h18;
  localparam logic [WB_AW-1:0] REG_PCFG_BASE = 8'h40;
  localparam logic [WB_AW-1:0] REG_PCFG_LAST = 8'h7C;

  // per-processor configuration word
  localparam int PCFG_W = 7;
  localparam int PCFG_GRP_LSB = 0;
  localparam int PCFG_ACCEPT = 2;
  localparam int PCFG_MODEIO = 3;
  localparam int PCFG_PASS = 4;
  localparam int PCFG_ORIG = 5;
  localparam int PCFG_SHARED = 6;
  localparam logic [PCFG_W-1:0] PCFG_RESET = 7'h00;

  // channel map write word and table entry layout
  localparam int CHMAP_CHAN_LSB = 0;
  localparam int CHMAP_ENT_LSB = 8;
  localparam int ENT_W = 8;
  localparam int ENT_PROC_LSB = 0;
  localparam int ENT_QUAD_LSB = 4;
  localparam int ENT_GRP_LSB = 6;

  // control and status fields
  localparam int CTRL_RING_EN = 0;
  localparam int STAT_IDLE_LSB = 0;
  localparam int STAT_SEEK_LSB = 4;
  localparam logic CTRL_RESET = 1'b0;

  // per-group ring state, gray along wait -> seek -> busy
  typedef enum logic [1:0] {
    RING_WAIT = 2'b00,
    RING_SEEK = 2'b01,
    RING_BUSY = 2'b11
  } iord_ring_state_type;

endpackage : iord_pkg

/* tb/iord_dispatch_chk.sv */
// port-level checker for the dispatcher, bound onto its top module
// assumes one clock domain and the synchronous reset rst_i
`timescale 1ns/1ps
module iord_dispatch_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus and command inputs
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cmd_valid_i,
  input wire logic [iord_pkg::CMD_W-1:0] cmd_code_i,
  input wire logic [iord_pkg::AJ_W-1:0] cmd_aj_i,
  // observed outputs
  input wire logic fwd_valid_o,
  input wire logic [iord_pkg::CMD_W-1:0] fwd_code_o,
  input wire logic [iord_pkg::AJ_W-1:0] fwd_aj_o,
  input wire logic cmd_reject_o,
  input wire logic [iord_pkg::N_PROC-1:0] proc_irq_o
);
  import iord_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus answer timing
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  // one processor interrupted per pulse
  property p_irq_onehot; $onehot0(proc_irq_o); endproperty
  a_irq_onehot: assert property (p_irq_onehot) else $error("two irqs");
  // forwarded requests stem from a command two cycles back
  property p_fwd_cause; fwd_valid_o |-> $past(cmd_valid_i, 2); endproperty
  a_fwd_cause: assert property (p_fwd_cause) else $error("fwd no cmd");
  property p_fwd_payload;
    fwd_valid_o |-> fwd_code_o == $past(cmd_code_i, 2) && fwd_aj_o == $past(cmd_aj_i, 2);
  endproperty
  a_fwd_payload: assert property (p_fwd_payload) else $error("fwd payload");
  property p_fwd_hold; !fwd_valid_o |-> $stable(fwd_code_o) && $stable(fwd_aj_o); endproperty
  a_fwd_hold: assert property (p_fwd_hold) else $error("fwd not held");
  property p_fwd_noset; fwd_valid_o |-> fwd_code_o != CMD_SET_IRQ; endproperty
  a_fwd_noset: assert property (p_fwd_noset) else $error("set code forwarded");
  property p_rej_cause; cmd_reject_o |-> $past(cmd_valid_i) || $past(cmd_valid_i, 2); endproperty
  a_rej_cause: assert property (p_rej_cause) else $error("reject no cmd");
  // main scenarios
  c_ack: cover property (wb_ack_o);
  c_fwd: cover property (fwd_valid_o);
  c_rej: cover property (cmd_reject_o);
  c_irq: cover property (proc_irq_o != '0);
endmodule : iord_dispatch_chk

bind iord_dispatch iord_dispatch_chk iord_dispatch_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
  .cmd_aj_i(cmd_aj_i), .fwd_valid_o(fwd_valid_o), .fwd_code_o(fwd_code_o),
  .fwd_aj_o(fwd_aj_o), .cmd_reject_o(cmd_reject_o), .proc_irq_o(proc_irq_o));

/* tb/iord_far_model.sv */
// processors and IO modules on the far side of the dispatcher
// assumes the bench calls its tasks right after a rising edge
`timescale 1ns/1ps
module iord_far_model (
  // clock
  input wire logic clk_i,
  // interrupt and command lines
  output logic irq_o,
  output logic [iord_pkg::GROUP_W-1:0] irq_group_o,
  output logic cmd_valid_o,
  output logic [iord_pkg::PROC_W-1:0] cmd_src_o,
  output logic [iord_pkg::CMD_W-1:0] cmd_code_o,
  output logic [iord_pkg::AJ_W-1:0] cmd_aj_o,
  output logic [iord_pkg::AK_W-1:0] cmd_ak_o
);
  import iord_pkg::*;
  // channel clear, limit and address codes (octal 14, 12, 11)
  localparam logic [CMD_W-1:0] C_CLEAR = 6'h0C;
  localparam logic [CMD_W-1:0] C_LIMIT = 6'h0A;
  localparam logic [CMD_W-1:0] C_ADDR = 6'h09;

  // quiet lines at time zero
  initial begin
    irq_o = 1'b0;
    irq_group_o = '0;
    cmd_valid_o = 1'b0;
    {cmd_src_o, cmd_code_o, cmd_aj_o, cmd_ak_o} = '1;
  end

  // inbound packet landed: one pulse toward the shared side
  task automatic send_irq(input logic [GROUP_W-1:0] g);
    irq_o <= 1'b1;
    irq_group_o <= g;
    @(posedge clk_i);
    irq_o <= 1'b0;
    irq_group_o <= ~g;
    @(posedge clk_i);
  endtask : send_irq

  // code travels with both operands; fields invert once dropped
  task automatic send_cmd(input logic [PROC_W-1:0] s, input logic [CMD_W-1:0] c,
                          input logic [AJ_W-1:0] j, input logic [AK_W-1:0] k);
    cmd_valid_o <= 1'b1;
    {cmd_src_o, cmd_code_o, cmd_aj_o, cmd_ak_o} <= {s, c, j, k};
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    {cmd_src_o, cmd_code_o, cmd_aj_o, cmd_ak_o} <= ~{s, c, j, k};
    @(posedge clk_i);
  endtask : send_cmd

  // address write last, since it starts the transfer
  task automatic start_channel(input logic [PROC_W-1:0] s, input logic [AJ_W-1:0] ch,
                               input logic [AK_W-1:0] lim, input logic [AK_W-1:0] adr);
    send_cmd(s, C_CLEAR, ch, '0);
    send_cmd(s, C_LIMIT, ch, lim);
    send_cmd(s, C_ADDR, ch, adr);
  endtask : start_channel
endmodule : iord_far_model

/* tb/test_iord_dispatch.sv */
// self-checking bench: registers, routing, refusals and the token ring
// assumes the far-side model and the bound port checker
`timescale 1ns/1ps
module test_iord_dispatch;
  import iord_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic [WB_AW-1:0] wb_adr = '0;
  logic [WB_DW-1:0] wb_wdat = '0;
  logic [WB_DW-1:0] wb_dat_o;
  logic wb_ack_o, irq, cmd_valid, fwd_valid_o, cmd_reject_o;
  logic [GROUP_W-1:0] irq_grp, fwd_group_o;
  logic [PROC_W-1:0] cmd_src, fwd_via_o, fwd_target_o, fwd_src_o;
  logic [CMD_W-1:0] cmd_code, fwd_code_o;
  logic [AJ_W-1:0] cmd_aj, fwd_aj_o;
  logic [AK_W-1:0] cmd_ak, fwd_ak_o;
  logic [QUAD_W-1:0] fwd_quadrant_o;
  logic [N_PROC-1:0] proc_irq_o;
  logic [N_PROC-1:0] last_irq = '0;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_fwd = 0;
  int n_rej = 0;
  int n_irq = 0;

  iord_dispatch iord_dispatch_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .io_irq_i(irq), .io_irq_group_i(irq_grp),
    .cmd_valid_i(cmd_valid), .cmd_src_i(cmd_src), .cmd_code_i(cmd_code),
    .cmd_aj_i(cmd_aj), .cmd_ak_i(cmd_ak), .fwd_valid_o(fwd_valid_o),
    .fwd_via_o(fwd_via_o), .fwd_quadrant_o(fwd_quadrant_o), .fwd_target_o(fwd_target_o),
    .fwd_group_o(fwd_group_o), .fwd_src_o(fwd_src_o), .fwd_code_o(fwd_code_o),
    .fwd_aj_o(fwd_aj_o), .fwd_ak_o(fwd_ak_o), .cmd_reject_o(cmd_reject_o),
    .proc_irq_o(proc_irq_o));
  iord_far_model iord_far_model_i (
    .clk_i(clk_i), .irq_o(irq), .irq_group_o(irq_grp), .cmd_valid_o(cmd_valid),
    .cmd_src_o(cmd_src), .cmd_code_o(cmd_code), .cmd_aj_o(cmd_aj), .cmd_ak_o(cmd_ak));

  always #5 clk_i = ~clk_i;

  // output pulses tallied where they stand
  always @(posedge clk_i) begin
    if (fwd_valid_o === 1'b1) n_fwd++;
    if (cmd_reject_o === 1'b1) n_rej++;
    if (proc_irq_o !== '0) begin
      n_irq++;
      last_irq = proc_irq_o;
    end
  end

  task automatic check(input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check

  // classic cycle: hold until ack sampled, then one idle cycle
  task automatic xfer(input logic we, input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] d,
                      output logic [WB_DW-1:0] q);
    int n;
    n = 0;
    {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_wdat} <= {2'b11, we, 4'hF, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) n_mismatch++;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
    @(posedge clk_i);
  endtask : xfer

  task automatic wr(input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] d);
    logic [WB_DW-1:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] e,
                        input logic [WB_DW-1:0] m = '1);
    logic [WB_DW-1:0] q;
    xfer(1'b0, a, '0, q);
    check(64'(q & m), 64'(e & m));
  endtask : rd_chk

  // bounded wait for a given number of interrupt pulses
  task automatic wait_irq(input int n);
    for (int i = 0; i < 60 && n_irq < n; i++) @(posedge clk_i);
  endtask : wait_irq

  task automatic t_regs();
    rd_chk(REG_CTRL, 32'h0000_0000);
    rd_chk(REG_STATUS, 32'h0000_000F, 32'h0000_000F);
    rd_chk(REG_PENDING, 32'h0000_0000);
    rd_chk(REG_PCFG_BASE, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'h0000_0000);
    wr(REG_QUADMAP, 32'h0000_0930);
    rd_chk(REG_QUADMAP, 32'h0000_0930, 32'h0000_FFFF);
    $display("t_regs done");
  endtask : t_regs

  // channel 105 held by processor 5 in quadrant 1, passed on by processor 3
  task automatic t_route();
    wr(8'h78, 32'h0000_0061);
    wr(8'h4C, 32'h0000_0011);
    wr(REG_CHMAP, 32'h0000_5569);
    wr(REG_CHMAP, 32'h0000_9520);
    wr(REG_CHMAP, 32'h0000_6530);
    rd_chk(REG_CHMAP, 32'h0000_0000);
    iord_far_model_i.start_channel(4'd14, 8'd105, 40'h00_0000_0100, 40'h12_3456_789A);
    repeat (4) @(posedge clk_i);
    check(64'(n_fwd), 64'd3);
    check(64'(fwd_code_o), 64'h09);
    check(64'(fwd_target_o), 64'd5);
    check(64'(fwd_quadrant_o), 64'd1);
    check(64'(fwd_via_o), 64'd3);
    check(64'(fwd_group_o), 64'd1);
    check(64'(fwd_src_o), 64'd14);
    check(64'(fwd_ak_o), 64'h12_3456_789A);
    check(64'(fwd_aj_o), 64'd105);
    $display("t_route done");
  endtask : t_route

  task automatic rej_one(input logic [PROC_W-1:0] s, input logic [AJ_W-1:0] ch);
    int r;
    int f;
    r = n_rej;
    f = n_fwd;
    iord_far_model_i.send_cmd(s, 6'h09, ch, '0);
    repeat (3) @(posedge clk_i);
    check(64'(n_rej), 64'(r + 1));
    check(64'(n_fwd), 64'(f));
  endtask : rej_one

  task automatic t_refuse();
    rej_one(4'd9, 8'd105);
    wr(8'h48, 32'h0000_0021);
    rej_one(4'd2, 8'd105);
    rej_one(4'd14, 8'h20);
    rej_one(4'd14, 8'h30);
    $display("t_refuse done");
  endtask : t_refuse

  // token skips unfit nodes, holds while busy, then wraps past 15
  task automatic t_ring();
    wr(8'h5C, 32'h0000_000D);
    wr(8'h78, 32'h0000_0065);
    wr(REG_CTRL, 32'h0000_0001);
    iord_far_model_i.send_irq(2'd1);
    wait_irq(1);
    check(64'(last_irq), 64'h0080);
    rd_chk(REG_STATUS, 32'h0000_000D, 32'h0000_000F);
    rd_chk(REG_HOLDER, 32'h0000_0070, 32'h0000_00F0);
    iord_far_model_i.send_cmd(4'd14, CMD_SET_IRQ, 8'd105, '0);
    rd_chk(REG_PENDING, 32'h0000_0200, 32'h0000_FF00);
    repeat (20) @(posedge clk_i);
    check(64'(n_irq), 64'd1);
    wr(8'h5C, 32'h0000_0001);
    wr(8'h48, 32'h0000_000D);
    wr(REG_DONE, 32'h0000_0002);
    wait_irq(2);
    check(64'(last_irq), 64'h0004);
    rd_chk(REG_PENDING, 32'h0000_0100, 32'h0000_FF00);
    wr(REG_DONE, 32'h0000_000F); // groups not in service must ignore their bits
    rd_chk(REG_PENDING, 32'h0000_0000);
    rd_chk(REG_STATUS, 32'h0000_000F, 32'h0000_000F);
    repeat (20) @(posedge clk_i);
    check(64'(n_irq), 64'd2);
    $display("t_ring done");
  endtask : t_ring

  task automatic stop_test();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_route();
    t_refuse();
    t_ring();
    stop_test();
  end

  // watchdog well beyond the few hundred cycles the tests take
  initial begin
    #200_000;
    n_mismatch++;
    stop_test();
  end
endmodule : test_iord_dispatch
